// file: dv/tbds_assertions.sv
// Purpose: Concurrent checks on the ports of the diagnostic flag block.
// Assumes: Bound into every tbds_top instance.
// Notes:   Flags are observed through the read data loaded at each setup edge.
`include "tbds_regs.svh"

module tbds_assertions #(
    parameter int IDLE_CYCLES = 10250,
    parameter int NAK_CNT_W   = 8
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    // Events.
    input  wire logic        receive_input_pin,
    input  wire logic        lost_token_timeout,
    input  wire logic        token_valid,
    input  wire logic        token_from_self,
    input  wire logic        response_seen,
    input  wire logic        token_received,
    input  wire logic        node_online,
    input  wire logic        nak_pulse,
    input  wire logic        successor_update
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire rd_setup = psel && !penable && !pwrite && paddr == `TBDS_OFF_DIAG;
    wire rd_done  = psel && penable && pready && !pwrite && paddr == `TBDS_OFF_DIAG;

    sequence ev_then_read(logic ev);
        ev ##1 rd_setup;
    endsequence

    sequence done_then_reread(int b);
        rd_done && prdata[b] ##1 rd_setup;
    endsequence

    // A read that showed no excess flag, with no negative acknowledgement at its setup or completion edge.
    sequence nak_free_read;
        rd_done && !prdata[3] && !nak_pulse && !$past(nak_pulse) ##1 rd_setup;
    endsequence

    pready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    reserved_bit_a: assert property (rd_setup |=> prdata[0] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("reserved bits not zero");
    rebuild_set_a: assert property (ev_then_read(lost_token_timeout) |=> prdata[7])
        else $error("rebuild flag not set");
    token_seen_a: assert property (ev_then_read(token_valid && !token_from_self) |=> prdata[4])
        else $error("token seen flag not set");
    activity_set_a: assert property (receive_input_pin [*3] ##3 rd_setup |=> prdata[5])
        else $error("activity flag not set");
    nak_kept_a: assert property (done_then_reread(3) |=> prdata[3])
        else $error("excess flag cleared by read");
    succ_kept_a: assert property (done_then_reread(1) |=> prdata[1])
        else $error("successor flag cleared by read");
    dup_cleared_a: assert property ((!response_seen && !token_received) ##0 done_then_reread(6) |=> !prdata[6])
        else $error("duplicate flag survived read");
    succ_set_a: assert property (ev_then_read(successor_update) |=> prdata[1])
        else $error("successor flag not set");
    dup_online_a: assert property (ev_then_read(node_online && token_received) |=> prdata[6])
        else $error("duplicate flag not set on token");
    nak_quiet_a: assert property (nak_free_read |=> !prdata[3])
        else $error("excess flag set without nak");
endmodule

bind tbds_top tbds_assertions #(.IDLE_CYCLES(IDLE_CYCLES), .NAK_CNT_W(NAK_CNT_W)) chk_u (.*);

// file: dv/tbds_partner.sv
// Purpose: Far side of the flag block: network line and protocol sequencer events.
// Assumes: Tasks are called just after a rising pclk edge.
// Notes:   Token qualifiers are inverted once the token cycle is over.
module tbds_partner (
    // Clock.
    input  wire logic pclk,
    // Line and events.
    output logic       receive_input_pin,
    output logic       lost_token_timeout,
    output logic       token_valid,
    output logic       token_from_self,
    output logic       token_eot_ok,
    output logic       token_trail_ok,
    output logic [7:0] token_did_first,
    output logic [7:0] token_did_second,
    output logic       response_seen,
    output logic       token_received,
    output logic       node_online,
    output logic       nak_pulse,
    output logic       successor_update,
    output logic [7:0] successor_addr_in
);
    initial begin
        {receive_input_pin, lost_token_timeout, token_valid, token_from_self, token_eot_ok} = '0;
        {token_trail_ok, token_did_first, token_did_second, response_seen, token_received} = '0;
        {node_online, nak_pulse, successor_update, successor_addr_in} = '0;
    end

    task automatic tok(input logic [7:0] f, input logic [7:0] s, input logic slf, input logic end_marker_char, input logic trl);
        token_valid <= 1'b1;
        {token_did_first, token_did_second, token_from_self, token_eot_ok, token_trail_ok} <= {f, s, slf, end_marker_char, trl};
        @(posedge pclk);
        token_valid <= 1'b0;
        {token_did_first, token_did_second, token_from_self, token_eot_ok, token_trail_ok} <= ~{f, s, slf, end_marker_char, trl};
    endtask

    task automatic resp();
        response_seen <= 1'b1;
        @(posedge pclk);
        response_seen <= 1'b0;
    endtask

    task automatic lost();
        lost_token_timeout <= 1'b1;
        @(posedge pclk);
        lost_token_timeout <= 1'b0;
    endtask

    task automatic got_token(input logic on);
        node_online <= on;
        token_received <= 1'b1;
        @(posedge pclk);
        token_received <= 1'b0;
    endtask

    task automatic burst(input int n);
        receive_input_pin <= 1'b1;
        repeat (n) @(posedge pclk);
        receive_input_pin <= 1'b0;
    endtask

    task automatic nak(input int n);
        repeat (n) begin
            nak_pulse <= 1'b1;
            @(posedge pclk);
            nak_pulse <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic succ(input logic [7:0] a);
        successor_update <= 1'b1;
        successor_addr_in <= a;
        @(posedge pclk);
        successor_update <= 1'b0;
        successor_addr_in <= ~a;
    endtask
endmodule

// file: dv/tbds_tb_top.sv
// Purpose: Self-checking bench for the network diagnostic flag block.
// Assumes: Every task is entered just after a rising pclk edge.
// Notes:   The idle count is shortened to keep the run brief.
`include "tbds_regs.svh"

module token_bus_diag_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE_CYCLES = 20;
    localparam int NAK_CNT_W   = 8;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        receive_input_pin, lost_token_timeout, token_valid, token_from_self, token_eot_ok;
    logic        token_trail_ok, response_seen, token_received, node_online, nak_pulse, successor_update;
    logic [7:0]  token_did_first, token_did_second, successor_addr_in;
    int          bad_count, check_count, cyc;

    tbds_top #(.IDLE_CYCLES(IDLE_CYCLES), .NAK_CNT_W(NAK_CNT_W)) dut_u (.*);
    tbds_partner net_u (.*);

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("BAD t=%0t timeout", $time);
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Keep leaves the bus selected so that the next call forms a back-to-back setup.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit keep);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        if (!keep) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic rdk(input logic [11:0] a, input logic [31:0] exp, input bit keep);
        apb(1'b0, a, 32'h0, keep);
        chk(rd, exp);
    endtask

    task automatic irqc(input logic exp);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
        @(posedge pclk);
    endtask

    task automatic tr(input logic [7:0] f, input logic [7:0] s, input logic slf, input logic end_marker_char, input logic trl,
                      input logic [31:0] exp, input bit keep);
        net_u.tok(f, s, slf, end_marker_char, trl);
        net_u.resp();
        rdk(`TBDS_OFF_DIAG, exp, keep);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        rdk(`TBDS_OFF_MASK, 32'h0, 0);
        apb(1'b0, 12'h040, 32'h0, 0);
        chk({31'h0, err}, 32'h1);
        repeat (IDLE_CYCLES + 5) @(posedge pclk);
        rdk(`TBDS_OFF_IRQ, 32'h4, 0);
        apb(1'b1, `TBDS_OFF_IRQ, 32'h4, 0);
        rdk(`TBDS_OFF_IRQ, 32'h0, 0);
        net_u.lost();
        rdk(`TBDS_OFF_DIAG, 32'h80, 0);
        rdk(`TBDS_OFF_DIAG, 32'h80, 0);
        apb(1'b1, `TBDS_OFF_CMD, 32'h1, 0);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        $display("test reset idle rebuild done");
        apb(1'b1, `TBDS_OFF_NODE, 32'h5A, 0);
        apb(1'b1, `TBDS_OFF_TENT, 32'h33, 0);
        tr(8'h5A, 8'h5A, 1'b0, 1'b1, 1'b1, 32'h50, 1);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        tr(8'h33, 8'h77, 1'b1, 1'b1, 1'b0, 32'h04, 0);
        tr(8'h5A, 8'h5A, 1'b1, 1'b1, 1'b0, 32'h00, 0);
        tr(8'h5A, 8'h5B, 1'b1, 1'b1, 1'b1, 32'h00, 0);
        tr(8'h33, 8'h5A, 1'b1, 1'b0, 1'b1, 32'h00, 0);
        net_u.got_token(1'b1);
        rdk(`TBDS_OFF_DIAG, 32'h40, 0);
        net_u.got_token(1'b0);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        net_u.burst(3);
        // The synchroniser keeps the flag setting for two more edges; a read inside them would not clear it.
        repeat (2) @(posedge pclk);
        rdk(`TBDS_OFF_DIAG, 32'h20, 1);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        $display("test token activity done");
        apb(1'b1, `TBDS_OFF_CFG, 32'h1, 0);
        net_u.nak(3);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        net_u.nak(1);
        rdk(`TBDS_OFF_DIAG, 32'h8, 1);
        rdk(`TBDS_OFF_DIAG, 32'h8, 0);
        irqc(1'b0);
        apb(1'b1, `TBDS_OFF_MASK, 32'h8, 0);
        irqc(1'b1);
        apb(1'b1, `TBDS_OFF_CMD, 32'h1, 0);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        irqc(1'b0);
        apb(1'b1, `TBDS_OFF_CFG, 32'h0, 0);
        net_u.nak(127);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        net_u.nak(1);
        rdk(`TBDS_OFF_DIAG, 32'h8, 0);
        apb(1'b1, `TBDS_OFF_CMD, 32'h1, 0);
        $display("test excess nak done");
        net_u.succ(8'h21);
        rdk(`TBDS_OFF_DIAG, 32'h2, 1);
        rdk(`TBDS_OFF_DIAG, 32'h2, 0);
        apb(1'b1, `TBDS_OFF_MASK, 32'h2, 0);
        irqc(1'b1);
        rdk(`TBDS_OFF_SUCC, 32'h21, 0);
        rdk(`TBDS_OFF_DIAG, 32'h0, 0);
        irqc(1'b0);
        net_u.tok(8'h01, 8'h01, 1'b0, 1'b1, 1'b1);
        fork
            rdk(`TBDS_OFF_DIAG, 32'h10, 1);
            begin
                @(posedge pclk);
                net_u.tok(8'h01, 8'h01, 1'b0, 1'b1, 1'b1);
            end
        join
        rdk(`TBDS_OFF_DIAG, 32'h10, 0);
        $display("test successor same cycle done");
        print_verdict();
    end
endmodule

// file: hdl/tbds_idle_timer.sv
// Purpose: Line idle timer that pulses once when the line stays low long enough.
// Assumes: line_high is already synchronised to pclk.
// Notes:   Re-arms only after the line goes high again.
module tbds_idle_timer #(
    parameter int IDLE_CYCLES = 10250,
    parameter int CNT_W       = 16
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Line level and timeout pulse.
    input  wire logic line_high,
    output logic      timeout
);

    logic [CNT_W-1:0] cnt_r;
    logic             fired_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r   <= '0;
            fired_r <= 1'b0;
            timeout <= 1'b0;
        end else if (line_high) begin
            cnt_r   <= '0;
            fired_r <= 1'b0;
            timeout <= 1'b0;
        end else if (!fired_r && cnt_r == CNT_W'(IDLE_CYCLES - 1)) begin
            fired_r <= 1'b1;
            timeout <= 1'b1;
        end else begin
            if (!fired_r) begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
            timeout <= 1'b0;
        end
    end

endmodule

// file: hdl/tbds_sync.sv
// Purpose: Two-stage synchroniser for a level arriving from a pin.
// Assumes: Input is asynchronous to pclk.
// Notes:   Only the second stage is visible outside.
module tbds_sync (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Level in and out.
    input  wire logic din,
    output logic      dout
);

    logic meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// file: hdl/tbds_top.sv
// Purpose: Diagnostic status flags of a token-bus node, with APB registers and one interrupt.
// Assumes: Protocol events arrive as one-cycle pulses on pclk; receive_input_pin is asynchronous.
// Notes:   APB access phase is always one cycle; read data is taken in the setup cycle.
//
// Behaviour
// RULE_01: Lost-token timer expiry sets the self-caused rebuild flag, bit 7.
// RULE_02: Both address bytes match node address plus response set duplicate flag, bit 6.
// RULE_03: While on line, every token received sets the duplicate flag.
// RULE_04: Any diagnostic register read clears the duplicate flag; the code clears it only on a read whose setup showed it set.
// RULE_05: A high level on the receive pin sets the line activity flag, bit 5.
// RULE_06: A token sent by another node sets the token observed flag, bit 4.
// RULE_07: Reaching 128 or 4 negative acknowledgements sets the excess flag, bit 3.
// RULE_08: Excess flag clears only on clear command; interrupts when masked in.
// RULE_09: Response to token whose first address byte matches probe address sets bit 2.
// RULE_10: Probe match checks the end marker, not second byte or trailing zeros.
// RULE_11: Successor register update sets successor changed flag, bit 1; interrupts when masked in.
// RULE_12: Successor flag clears only on successor register read, not diagnostic read.
// RULE_13: Low reserved bit of the diagnostic register carries no meaning.
// RULE_14: Receive input idle for 82 microseconds raises the line idle timeout flag.
// RULE_15: Read clears act on completed reads; a same-cycle event stays set.
//
// The APB interface to the registers and the address map were left to the implementer.
`include "tbds_regs.svh"

module tbds_top
    import tbds_pkg::*;
#(
    parameter int IDLE_CYCLES = `TBDS_IDLE_CYC,
    parameter int NAK_CNT_W   = 8
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Network receive pin.
    input  wire logic        receive_input_pin,
    // Events from the protocol sequencer.
    input  wire logic        lost_token_timeout,
    input  wire logic        token_valid,
    input  wire logic        token_from_self,
    input  wire logic        token_eot_ok,
    input  wire logic        token_trail_ok,
    input  wire logic [7:0]  token_did_first,
    input  wire logic [7:0]  token_did_second,
    input  wire logic        response_seen,
    input  wire logic        token_received,
    input  wire logic        node_online,
    input  wire logic        nak_pulse,
    input  wire logic        successor_update,
    input  wire logic [7:0]  successor_addr_in,
    // Interrupt.
    output logic             irq
);

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    logic              rx_level;
    logic              idle_pulse;
    tbds_tok_state_t   tok_state_r;
    logic              dup_pend_r;
    logic              probe_pend_r;
    logic              rebuild_r;
    logic              dup_r;
    logic              act_r;
    logic              token_r;
    logic              nak_r;
    logic              probe_r;
    logic              succ_r;
    logic              idle_r;
    logic [7:0]        mask_r;
    logic [7:0]        node_r;
    logic [7:0]        tent_r;
    logic [7:0]        succ_addr_r;
    logic              nak_sel_r;
    logic [NAK_CNT_W-1:0] nak_cnt_r;
    logic [NAK_CNT_W-1:0] nak_cnt_nxt;
    logic [NAK_CNT_W-1:0] nak_limit;
    logic [7:0]        shown_r;
    logic              succ_shown_r;
    logic [7:0]        diag_val;
    logic [7:0]        irq_val;
    logic [31:0]       rd_mux;
    logic              mapped;
    logic              setup;
    logic              done;
    logic              wr_done;
    logic              rd_done;
    logic              rd_diag;
    logic              rd_succ;
    logic              clear_cmd;
    logic              idle_w1c;
    logic              resp_hit;
    logic              tok_other;
    logic              dup_match;
    logic              probe_match;

    tbds_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (receive_input_pin),
        .dout    (rx_level)
    );

    tbds_idle_timer #(
        .IDLE_CYCLES (IDLE_CYCLES),
        .CNT_W       (16)
    ) u_idle (
        .pclk      (pclk),
        .presetn   (presetn),
        .line_high (rx_level),
        .timeout   (idle_pulse)
    );

    // Bus phase decode.
    assign setup   = psel && !penable;
    assign done    = psel && penable && pready;
    assign wr_done = done && pwrite && !pslverr;
    assign rd_done = done && !pwrite && !pslverr;
    assign rd_diag = rd_done && hit(paddr, `TBDS_OFF_DIAG);
    assign rd_succ = rd_done && hit(paddr, `TBDS_OFF_SUCC);
    assign clear_cmd = wr_done && hit(paddr, `TBDS_OFF_CMD) && pwdata[`TBDS_CMD_CLEAR];
    assign idle_w1c  = wr_done && hit(paddr, `TBDS_OFF_IRQ) && pwdata[`TBDS_IRQ_IDLE];

    assign mapped = hit(paddr, `TBDS_OFF_DIAG) || hit(paddr, `TBDS_OFF_MASK) ||
                    hit(paddr, `TBDS_OFF_NODE) || hit(paddr, `TBDS_OFF_TENT) ||
                    hit(paddr, `TBDS_OFF_SUCC) || hit(paddr, `TBDS_OFF_CMD)  ||
                    hit(paddr, `TBDS_OFF_CFG)  || hit(paddr, `TBDS_OFF_IRQ);

    // Token matching.
    assign tok_other   = token_valid && !token_from_self;
    assign dup_match   = token_eot_ok && token_trail_ok &&
                         (token_did_first == node_r) && (token_did_second == node_r); // [RULE_02]
    assign probe_match = token_eot_ok && (token_did_first == tent_r); // [RULE_10]
    assign resp_hit    = (tok_state_r == TBDS_TOK_WAIT) && response_seen;

    // Register views.
    always_comb begin
        diag_val = 8'h00; // [RULE_13]
        diag_val[`TBDS_BIT_REBUILD] = rebuild_r;
        diag_val[`TBDS_BIT_DUP]     = dup_r;
        diag_val[`TBDS_BIT_ACT]     = act_r;
        diag_val[`TBDS_BIT_TOKEN]   = token_r;
        diag_val[`TBDS_BIT_NAK]     = nak_r;
        diag_val[`TBDS_BIT_PROBE]   = probe_r;
        diag_val[`TBDS_BIT_SUCC]    = succ_r;
    end

    always_comb begin
        irq_val = 8'h00;
        irq_val[`TBDS_IRQ_SUCC] = succ_r;
        irq_val[`TBDS_IRQ_IDLE] = idle_r;
        irq_val[`TBDS_IRQ_NAK]  = nak_r;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit(paddr, `TBDS_OFF_DIAG): rd_mux[7:0] = diag_val;
            hit(paddr, `TBDS_OFF_MASK): rd_mux[7:0] = mask_r;
            hit(paddr, `TBDS_OFF_NODE): rd_mux[7:0] = node_r;
            hit(paddr, `TBDS_OFF_TENT): rd_mux[7:0] = tent_r;
            hit(paddr, `TBDS_OFF_SUCC): rd_mux[7:0] = succ_addr_r;
            hit(paddr, `TBDS_OFF_CFG):  rd_mux[`TBDS_CFG_NAK_SEL] = nak_sel_r;
            hit(paddr, `TBDS_OFF_IRQ):  rd_mux[7:0] = irq_val;
            default:                    rd_mux = 32'h0000_0000;
        endcase
    end

    // APB answer: ready in the cycle after setup, data and error captured at setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h0000_0000;
            shown_r      <= 8'h00;
            succ_shown_r <= 1'b0;
        end else if (setup) begin
            pready       <= 1'b1;
            pslverr      <= !mapped;
            prdata       <= pwrite ? 32'h0000_0000 : rd_mux;
            shown_r      <= diag_val;
            succ_shown_r <= succ_r;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Software-written registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r    <= 8'h00;
            node_r    <= 8'h00;
            tent_r    <= 8'h00;
            nak_sel_r <= 1'b0;
        end else if (wr_done) begin
            if (hit(paddr, `TBDS_OFF_MASK)) begin
                mask_r <= pwdata[7:0];
            end
            if (hit(paddr, `TBDS_OFF_NODE)) begin
                node_r <= pwdata[7:0];
            end
            if (hit(paddr, `TBDS_OFF_TENT)) begin
                tent_r <= pwdata[7:0];
            end
            if (hit(paddr, `TBDS_OFF_CFG)) begin
                nak_sel_r <= pwdata[`TBDS_CFG_NAK_SEL];
            end
        end
    end

    // Successor address is written by the sequencer only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            succ_addr_r <= 8'h00;
        end else if (successor_update) begin
            succ_addr_r <= successor_addr_in;
        end
    end

    // Token tracker: remember a match until the response or the next token.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tok_state_r  <= TBDS_TOK_IDLE;
            dup_pend_r   <= 1'b0;
            probe_pend_r <= 1'b0;
        end else begin
            case (tok_state_r)
                TBDS_TOK_IDLE: begin
                    if (token_valid) begin
                        tok_state_r  <= TBDS_TOK_WAIT;
                        dup_pend_r   <= dup_match;
                        probe_pend_r <= probe_match;
                    end
                end
                TBDS_TOK_WAIT: begin
                    if (token_valid) begin
                        dup_pend_r   <= dup_match;
                        probe_pend_r <= probe_match;
                    end else if (response_seen) begin
                        tok_state_r <= TBDS_TOK_IDLE;
                    end
                end
                default: begin
                    tok_state_r <= TBDS_TOK_IDLE;
                end
            endcase
        end
    end

    // Self-caused rebuild flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rebuild_r <= 1'b0;
        end else if (lost_token_timeout) begin
            rebuild_r <= 1'b1; // [RULE_01]
        end else if (clear_cmd) begin
            rebuild_r <= 1'b0;
        end
    end

    // Duplicate node flag; only bits shown to the reader are cleared.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dup_r <= 1'b0;
        end else if ((resp_hit && dup_pend_r && !token_valid) || (node_online && token_received)) begin
            dup_r <= 1'b1; // [RULE_02] [RULE_03] [RULE_15]
        end else if (rd_diag && shown_r[`TBDS_BIT_DUP]) begin
            dup_r <= 1'b0; // [RULE_04] [RULE_15]
        end
    end

    // Line activity flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_r <= 1'b0;
        end else if (rx_level) begin
            act_r <= 1'b1; // [RULE_05] [RULE_15]
        end else if (rd_diag && shown_r[`TBDS_BIT_ACT]) begin
            act_r <= 1'b0;
        end
    end

    // Token observed flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            token_r <= 1'b0;
        end else if (tok_other) begin
            token_r <= 1'b1; // [RULE_06] [RULE_15]
        end else if (rd_diag && shown_r[`TBDS_BIT_TOKEN]) begin
            token_r <= 1'b0;
        end
    end

    // Probe address flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            probe_r <= 1'b0;
        end else if (resp_hit && probe_pend_r && !token_valid) begin
            probe_r <= 1'b1; // [RULE_09] [RULE_15]
        end else if (rd_diag && shown_r[`TBDS_BIT_PROBE]) begin
            probe_r <= 1'b0;
        end
    end

    // Negative acknowledgement counter, saturating.
    assign nak_limit   = nak_sel_r ? NAK_CNT_W'(`TBDS_NAK_LIMIT_SHORT) : NAK_CNT_W'(`TBDS_NAK_LIMIT_LONG);
    assign nak_cnt_nxt = (&nak_cnt_r) ? nak_cnt_r : nak_cnt_r + NAK_CNT_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nak_cnt_r <= '0;
        end else if (nak_pulse) begin
            nak_cnt_r <= nak_cnt_nxt;
        end else if (clear_cmd) begin
            nak_cnt_r <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nak_r <= 1'b0;
        end else if (nak_pulse && nak_cnt_nxt >= nak_limit) begin
            nak_r <= 1'b1; // [RULE_07]
        end else if (clear_cmd) begin
            nak_r <= 1'b0; // [RULE_08]
        end
    end

    // Successor changed flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            succ_r <= 1'b0;
        end else if (successor_update) begin
            succ_r <= 1'b1; // [RULE_11]
        end else if (rd_succ && succ_shown_r) begin
            succ_r <= 1'b0; // [RULE_12] [RULE_15]
        end
    end

    // Line idle timeout flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_r <= 1'b0;
        end else if (idle_pulse) begin
            idle_r <= 1'b1; // [RULE_14]
        end else if (clear_cmd || idle_w1c) begin
            idle_r <= 1'b0;
        end
    end

    // Level interrupt while any unmasked source is set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_val & mask_r); // [RULE_08] [RULE_11]
        end
    end

endmodule

// file: include/tbds_pkg.sv
// Purpose: Types shared by the network diagnostic flag block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Offsets and counts live in tbds_regs.svh.
package tbds_pkg;

    typedef enum logic [1:0] {
        TBDS_TOK_IDLE = 2'b01,
        TBDS_TOK_WAIT = 2'b10
    } tbds_tok_state_t;

endpackage

// file: include/tbds_regs.svh
// Purpose: Register map, field positions and timing counts of the network diagnostic flag block.
// Assumes: APB byte addresses, 32-bit data, 125 MHz pclk.
// Notes:   Definitions only.
`ifndef TBDS_REGS_SVH
`define TBDS_REGS_SVH

`define TBDS_ADDR_W          12
`define TBDS_OFF_DIAG        12'h000
`define TBDS_OFF_MASK        12'h004
`define TBDS_OFF_NODE        12'h008
`define TBDS_OFF_TENT        12'h00C
`define TBDS_OFF_SUCC        12'h010
`define TBDS_OFF_CMD         12'h014
`define TBDS_OFF_CFG         12'h018
`define TBDS_OFF_IRQ         12'h01C

`define TBDS_BIT_REBUILD     7
`define TBDS_BIT_DUP         6
`define TBDS_BIT_ACT         5
`define TBDS_BIT_TOKEN       4
`define TBDS_BIT_NAK         3
`define TBDS_BIT_PROBE       2
`define TBDS_BIT_SUCC        1

`define TBDS_IRQ_SUCC        1
`define TBDS_IRQ_IDLE        2
`define TBDS_IRQ_NAK         3

`define TBDS_CMD_CLEAR       0
`define TBDS_CFG_NAK_SEL     0

`define TBDS_NAK_LIMIT_LONG  128
`define TBDS_NAK_LIMIT_SHORT 4

`define TBDS_CLK_MHZ         125
`define TBDS_IDLE_US         82
`define TBDS_IDLE_CYC        (`TBDS_IDLE_US * `TBDS_CLK_MHZ)

`endif
